// ---- sys_cmd_cfg.svh ----
`ifndef SYS_CMD_CFG_SVH
`define SYS_CMD_CFG_SVH
`define PKT_TYPE 8'hc0
`define GRP_SYS 8'h02
`define ID_DEC 8'h0a
`define ID_WR 8'h0b
`define ID_RD 8'h0c
`define ID_ADDR 8'h0d
`define DEC_LEN_MIN 8'h1e
`define DEC_LEN_MAX 8'h39
`define WR_LEN_MIN 8'h04
`define WR_LEN_MAX 8'h23
`define RD_LEN 8'h03
`define ADDR_LEN 8'h06
`define HDR_BYTES 8'h04
`define RSP_FIX_LEN 8'h02
`define ARR_RSP_BASE 8'h03
`define RSP_DATA_IDX 8'h07
`define KEY_POS 1
`define KEY_BYTES 16
`define NONCE_POS 17
`define NONCE_BYTES 13
`define CT_POS 30
`define ARR_POS 3
`define XFER_MAX 8'h20
`define STORE_BYTES 17'h00100
`define PAY_MAX 57
`define RES_OK 16'h0000
`define RES_UNKNOWN 16'h0101
`define RES_RANGE 16'h0102
`define TXT_DEC_MIN 16'h000e
`define TXT_RD_MIN 16'h000d
`endif

// ---- sys_cmd_pkg.sv ----
package sys_cmd_pkg;
    typedef enum logic [1:0] {
        DEV_HDR = 2'b00,
        DEV_PAY = 2'b01,
        DEV_EXEC = 2'b10,
        DEV_RSP = 2'b11
    } dev_state_t;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_TX = 2'b01,
        HOST_RX = 2'b10
    } host_state_t;
endpackage : sys_cmd_pkg

// ---- cmd_link_if.sv ----
`timescale 1ns/10ps
interface cmd_link_if;
    logic h2d_valid;
    logic [7:0] h2d_data;
    logic h2d_ready;
    logic d2h_valid;
    logic [7:0] d2h_data;
    logic d2h_ready;
    modport dev (
        input h2d_valid, h2d_data, d2h_ready,
        output h2d_ready, d2h_valid, d2h_data
    );
    modport host (
        output h2d_valid, h2d_data, d2h_ready,
        input h2d_ready, d2h_valid, d2h_data
    );
endinterface : cmd_link_if

// ---- two_entry_buf.sv ----
`timescale 1ns/10ps
module two_entry_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic full_o,
    output logic empty_o
);
    logic spare_valid;
    logic [WIDTH-1:0] spare_data;
    logic push;
    logic pop;

    initial begin
        if (DEPTH != 2 || WIDTH < 1) $error("two_entry_buf: DEPTH must be 2");
    end

    assign push = in_valid_i & ~spare_valid;
    assign pop = out_valid_o & out_ready_i;
    assign in_ready_o = ~spare_valid;
    assign full_o = spare_valid;
    assign empty_o = ~out_valid_o;

    // Head is the output register so the link sees flop-driven data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
            spare_valid <= 1'b0;
            spare_data <= '0;
        end else if (pop) begin
            if (spare_valid) begin
                out_data_o <= spare_data;
                spare_valid <= push;
                spare_data <= in_data_i;
            end else begin
                out_valid_o <= push;
                out_data_o <= in_data_i;
            end
        end else if (push) begin
            if (!out_valid_o) begin
                out_valid_o <= 1'b1;
                out_data_o <= in_data_i;
            end else begin
                spare_valid <= 1'b1;
                spare_data <= in_data_i;
            end
        end
    end
endmodule : two_entry_buf

// ---- cmd_device.sv ----
`timescale 1ns/10ps
`include "sys_cmd_cfg.svh"
module cmd_device #(
    parameter int PAY_MAX = `PAY_MAX,
    // Arbitrary die identity used to build the factory address
    parameter logic [47:0] DIE_ID = 48'h1a2b_3c4d_5e6f
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    cmd_link_if.dev link,
    input wire logic privacy_i,
    output logic [47:0] pub_addr_o,
    output logic [47:0] peer_addr_o,
    output logic [15:0] text_len_o,
    output logic busy_o
);
    sys_cmd_pkg::dev_state_t state;
    logic rx_ready;
    logic [1:0] hcnt;
    logic [7:0] h_type;
    logic [7:0] h_len;
    logic [7:0] h_grp;
    logic [7:0] h_id;
    logic [7:0] pcnt;
    logic [7:0] pay [PAY_MAX];
    logic [7:0] mem [256];
    logic [15:0] res;
    logic [7:0] rlen;
    logic [7:0] dlen;
    logic arr;
    logic [7:0] ridx;
    logic [47:0] addr;
    logic [23:0] lfsr;
    logic priv_meta;
    logic priv_sync;
    logic take;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] tx_byte;
    logic [15:0] off;
    logic [7:0] cnt;
    logic [16:0] span;
    logic hdr_ok;
    logic dec_ok;
    logic wr_ok;
    logic rd_ok;
    logic ad_ok;

    initial begin
        if (PAY_MAX < `PAY_MAX) $error("cmd_device: PAY_MAX too small");
    end

    function automatic logic [47:0] factory_addr(input logic [47:0] die);
        factory_addr = die ^ {die[23:0], die[47:24]};
    endfunction : factory_addr

    // Symmetric keystream, so the encrypt side undoes with the same key/nonce
    function automatic logic [7:0] keystream(input logic [7:0] i);
        logic [7:0] k;
        logic [7:0] n;
        k = pay[`KEY_POS + int'(i % 8'd16)];
        n = pay[`NONCE_POS + int'(i % 8'd13)];
        keystream = k ^ n ^ i;
    endfunction : keystream

    assign take = link.h2d_valid & rx_ready;
    assign off = {pay[1], pay[0]};
    assign cnt = pay[2];
    assign span = {1'b0, off} + {9'h000, cnt};
    assign hdr_ok = (h_type == `PKT_TYPE) && (h_grp == `GRP_SYS);
    // Length byte of the structure must agree with the packet length
    assign dec_ok = (h_len >= `DEC_LEN_MIN) && (h_len <= `DEC_LEN_MAX)
        && (pay[0] == h_len - 8'h01);
    assign wr_ok = (h_len >= `WR_LEN_MIN) && (h_len <= `WR_LEN_MAX)
        && (cnt != 8'h00) && (cnt <= `XFER_MAX)
        && (h_len == cnt + `ARR_RSP_BASE)
        && (span <= `STORE_BYTES);
    assign rd_ok = (h_len == `RD_LEN) && (cnt != 8'h00)
        && (cnt <= `XFER_MAX) && (span <= `STORE_BYTES);
    assign ad_ok = (h_len == `ADDR_LEN);

    always_comb begin
        logic [7:0] di;
        di = ridx - `RSP_DATA_IDX;
        case (ridx)
            8'h00: tx_byte = h_type;
            8'h01: tx_byte = rlen;
            8'h02: tx_byte = h_grp;
            8'h03: tx_byte = h_id;
            8'h04: tx_byte = res[7:0];
            8'h05: tx_byte = res[15:8];
            8'h06: tx_byte = dlen;
            default: begin
                if (h_id == `ID_DEC) begin
                    tx_byte = pay[`CT_POS + int'(di)] ^ keystream(di);
                end else begin
                    tx_byte = mem[off[7:0] + di];
                end
            end
        endcase
    end

    assign tx_valid = (state == sys_cmd_pkg::DEV_RSP);

    // Stall by the host backs up here instead of dropping bytes
    two_entry_buf #(.WIDTH(8), .DEPTH(2)) u_rsp_buf (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(tx_valid),
        .in_data_i(tx_byte),
        .in_ready_o(tx_ready),
        .out_valid_o(link.d2h_valid),
        .out_data_o(link.d2h_data),
        .out_ready_i(link.d2h_ready),
        .full_o(),
        .empty_o()
    );

    assign link.h2d_ready = rx_ready;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= sys_cmd_pkg::DEV_HDR;
            rx_ready <= 1'b1;
            hcnt <= 2'd0;
            pcnt <= 8'h00;
            ridx <= 8'h00;
            h_type <= 8'h00;
            h_len <= 8'h00;
            h_grp <= 8'h00;
            h_id <= 8'h00;
        end else begin
            case (state)
                sys_cmd_pkg::DEV_HDR: begin
                    if (take) begin
                        hcnt <= hcnt + 2'd1;
                        case (hcnt)
                            2'd0: h_type <= link.h2d_data;
                            2'd1: h_len <= link.h2d_data;
                            2'd2: h_grp <= link.h2d_data;
                            default: h_id <= link.h2d_data;
                        endcase
                        if (hcnt == 2'd3) begin
                            pcnt <= 8'h00;
                            if (h_len == 8'h00) begin
                                rx_ready <= 1'b0;
                                state <= sys_cmd_pkg::DEV_EXEC;
                            end else begin
                                state <= sys_cmd_pkg::DEV_PAY;
                            end
                        end
                    end
                end
                sys_cmd_pkg::DEV_PAY: begin
                    if (take) begin
                        pcnt <= pcnt + 8'h01;
                        if (pcnt + 8'h01 == h_len) begin
                            rx_ready <= 1'b0;
                            state <= sys_cmd_pkg::DEV_EXEC;
                        end
                    end
                end
                sys_cmd_pkg::DEV_EXEC: begin
                    ridx <= 8'h00;
                    state <= sys_cmd_pkg::DEV_RSP;
                end
                sys_cmd_pkg::DEV_RSP: begin
                    if (tx_ready) begin
                        ridx <= ridx + 8'h01;
                        if (ridx == rlen + 8'h03) begin
                            rx_ready <= 1'b1;
                            state <= sys_cmd_pkg::DEV_HDR;
                        end
                    end
                end
                default: state <= sys_cmd_pkg::DEV_HDR;
            endcase
        end
    end

    // Bytes past the buffer are counted but dropped; such lengths fail anyway
    always_ff @(posedge clk_i) begin
        if (state == sys_cmd_pkg::DEV_PAY && take && int'(pcnt) < PAY_MAX) begin
            pay[int'(pcnt)] <= link.h2d_data;
        end
    end

    // Storage contents survive reset, as non-volatile data would
    always_ff @(posedge clk_i) begin
        if (state == sys_cmd_pkg::DEV_EXEC && hdr_ok && h_id == `ID_WR && wr_ok) begin
            for (int i = 0; i < 32; i++) begin
                if (i < int'(cnt)) begin
                    mem[off[7:0] + 8'(i)] <= pay[`ARR_POS + i];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            res <= `RES_OK;
            rlen <= `RSP_FIX_LEN;
            dlen <= 8'h00;
            arr <= 1'b0;
            text_len_o <= 16'h0000;
        end else if (state == sys_cmd_pkg::DEV_EXEC) begin
            res <= `RES_RANGE;
            rlen <= `RSP_FIX_LEN;
            dlen <= 8'h00;
            arr <= 1'b0;
            text_len_o <= 16'h0000;
            if (!hdr_ok || h_id < `ID_DEC || h_id > `ID_ADDR) begin
                res <= `RES_UNKNOWN;
            end else if (h_id == `ID_DEC) begin
                rlen <= `ARR_RSP_BASE;
                arr <= 1'b1;
                if (dec_ok) begin
                    res <= `RES_OK;
                    // Payload is length byte, key and nonce, then n data bytes
                    dlen <= h_len - `DEC_LEN_MIN;
                    rlen <= h_len - 8'h1b;
                    text_len_o <= `TXT_DEC_MIN
                        + {7'h00, h_len - `DEC_LEN_MIN, 1'b0};
                end
            end else if (h_id == `ID_RD) begin
                rlen <= `ARR_RSP_BASE;
                arr <= 1'b1;
                if (rd_ok) begin
                    res <= `RES_OK;
                    dlen <= cnt;
                    rlen <= cnt + `ARR_RSP_BASE;
                    text_len_o <= `TXT_RD_MIN
                        + {7'h00, cnt, 1'b0};
                end
            end else if ((h_id == `ID_WR && wr_ok) || (h_id == `ID_ADDR && ad_ok)) begin
                res <= `RES_OK;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr <= factory_addr(DIE_ID);
        end else if (state == sys_cmd_pkg::DEV_EXEC && hdr_ok && h_id == `ID_ADDR
                && ad_ok) begin
            if ({pay[5], pay[4], pay[3], pay[2], pay[1], pay[0]} == 48'h0) begin
                addr <= factory_addr(DIE_ID);
            end else begin
                addr <= {pay[5], pay[4], pay[3], pay[2], pay[1], pay[0]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            priv_meta <= 1'b0;
            priv_sync <= 1'b0;
            lfsr <= 24'h00_0001;
            pub_addr_o <= 48'h0;
            peer_addr_o <= 48'h0;
            busy_o <= 1'b0;
        end else begin
            priv_meta <= privacy_i;
            priv_sync <= priv_meta;
            lfsr <= {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
            pub_addr_o <= addr;
            peer_addr_o <= priv_sync ? {2'b11, lfsr[21:0], lfsr} : addr;
            busy_o <= (state != sys_cmd_pkg::DEV_HDR) || (hcnt != 2'd0);
        end
    end
endmodule : cmd_device

// ---- cmd_host.sv ----
`timescale 1ns/10ps
`include "sys_cmd_cfg.svh"
module cmd_host (
    input wire logic clk_i,
    input wire logic resetn_i,
    cmd_link_if.host link,
    input wire logic req_valid_i,
    input wire logic [7:0] req_id_i,
    input wire logic [7:0] req_len_i,
    input wire logic [15:0] req_off_i,
    input wire logic [7:0] req_cnt_i,
    output logic req_ready_o,
    output logic req_err_o,
    input wire logic pay_valid_i,
    input wire logic [7:0] pay_data_i,
    output logic pay_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    input wire logic rsp_ready_i,
    output logic rsp_done_o,
    output logic [15:0] rsp_result_o,
    output logic [7:0] rsp_id_o
);
    sys_cmd_pkg::host_state_t state;
    logic [7:0] id;
    logic [7:0] len;
    logic [7:0] idx;
    logic [7:0] rx_len;
    logic [16:0] span;
    logic ok;
    logic got;
    logic sent;

    assign span = {1'b0, req_off_i} + {9'h000, req_cnt_i};
    assign sent = link.h2d_valid & link.h2d_ready;
    assign got = link.d2h_valid & link.d2h_ready;

    always_comb begin
        case (req_id_i)
            `ID_DEC: ok = (req_len_i >= `DEC_LEN_MIN)
                && (req_len_i <= `DEC_LEN_MAX);
            `ID_WR: ok = (req_len_i == req_cnt_i + `ARR_RSP_BASE)
                && (req_cnt_i != 8'h00) && (req_cnt_i <= `XFER_MAX)
                && (span <= `STORE_BYTES);
            `ID_RD: ok = (req_len_i == `RD_LEN) && (req_cnt_i != 8'h00)
                && (req_cnt_i <= `XFER_MAX)
                && (span <= `STORE_BYTES);
            `ID_ADDR: ok = (req_len_i == `ADDR_LEN);
            default: ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= sys_cmd_pkg::HOST_IDLE;
            id <= 8'h00;
            len <= 8'h00;
            idx <= 8'h00;
            rx_len <= 8'h00;
            req_ready_o <= 1'b1;
            req_err_o <= 1'b0;
            pay_ready_o <= 1'b0;
            link.h2d_valid <= 1'b0;
            link.h2d_data <= 8'h00;
            link.d2h_ready <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
            rsp_done_o <= 1'b0;
            rsp_result_o <= 16'h0000;
            rsp_id_o <= 8'h00;
        end else begin
            req_err_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_done_o <= 1'b0;
            case (state)
                sys_cmd_pkg::HOST_IDLE: begin
                    if (req_valid_i && req_ready_o) begin
                        req_err_o <= ~ok;
                        if (ok) begin
                            req_ready_o <= 1'b0;
                            id <= req_id_i;
                            len <= req_len_i;
                            idx <= 8'h00;
                            link.h2d_valid <= 1'b1;
                            link.h2d_data <= `PKT_TYPE;
                            state <= sys_cmd_pkg::HOST_TX;
                        end
                    end
                end
                sys_cmd_pkg::HOST_TX: begin
                    // One byte in flight; header bytes go back to back, a bubble per payload byte keeps the slot simple
                    if (sent) begin
                        idx <= idx + 8'h01;
                        link.h2d_valid <= 1'b0;
                        if (idx + 8'h01 == len + `HDR_BYTES) begin
                            idx <= 8'h00;
                            link.d2h_ready <= rsp_ready_i;
                            state <= sys_cmd_pkg::HOST_RX;
                        end else if (idx + 8'h01 >= `HDR_BYTES) begin
                            pay_ready_o <= 1'b1;
                        end else begin
                            link.h2d_valid <= 1'b1;
                            case (idx)
                                8'h00: link.h2d_data <= len;
                                8'h01: link.h2d_data <= `GRP_SYS;
                                default: link.h2d_data <= id;
                            endcase
                        end
                    end else if (pay_valid_i && pay_ready_o) begin
                        pay_ready_o <= 1'b0;
                        link.h2d_valid <= 1'b1;
                        link.h2d_data <= pay_data_i;
                    end
                end
                sys_cmd_pkg::HOST_RX: begin
                    link.d2h_ready <= rsp_ready_i;
                    if (got) begin
                        idx <= idx + 8'h01;
                        case (idx)
                            8'h01: rx_len <= link.d2h_data;
                            8'h03: rsp_id_o <= link.d2h_data;
                            8'h04: rsp_result_o[7:0] <= link.d2h_data;
                            8'h05: rsp_result_o[15:8] <= link.d2h_data;
                            default: begin
                                if (idx >= 8'h06) begin
                                    rsp_valid_o <= 1'b1;
                                    rsp_data_o <= link.d2h_data;
                                end
                            end
                        endcase
                        if (idx >= 8'h03 && idx == rx_len + 8'h03) begin
                            rsp_done_o <= 1'b1;
                            req_ready_o <= 1'b1;
                            link.d2h_ready <= 1'b0;
                            state <= sys_cmd_pkg::HOST_IDLE;
                        end
                    end
                end
                default: state <= sys_cmd_pkg::HOST_IDLE;
            endcase
        end
    end
endmodule : cmd_host

// ---- sys_cmd_assertions.sv ----
`timescale 1ns/10ps
module sys_cmd_assertions (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic h2d_valid,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_ready,
    input wire logic d2h_valid,
    input wire logic [7:0] d2h_data,
    input wire logic d2h_ready
);
    logic [7:0] hidx, hlen, hid, didx, dlen;
    wire h_take = h2d_valid && h2d_ready;
    wire d_take = d2h_valid && d2h_ready;
    wire h_last = h_take && hidx >= 8'h03 && hidx == hlen + 8'h03;
    wire d_end = d_take && didx >= 8'h03 && didx == dlen + 8'h03;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) hidx <= 8'h00;
        else if (h_last) hidx <= 8'h00;
        else if (h_take) hidx <= hidx + 8'h01;
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) didx <= 8'h00;
        else if (d_end) didx <= 8'h00;
        else if (d_take) didx <= didx + 8'h01;
    end
    // Header fields kept so the reply can be matched to its command
    always_ff @(posedge clk_i) begin
        if (h_take && hidx == 8'h01) hlen <= h2d_data;
        if (h_take && hidx == 8'h03) hid <= h2d_data;
        if (d_take && didx == 8'h01) dlen <= d2h_data;
    end
    h2d_hold_a: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
        else $error("host byte dropped before taken");
    d2h_hold_a: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
        else $error("reply byte lost under stall");
    cmd_type_a: assert property (h_take && hidx == 8'h00 |-> h2d_data == 8'hc0)
        else $error("command type byte wrong");
    rsp_type_a: assert property (d_take && didx == 8'h00 |-> d2h_data == 8'hc0)
        else $error("reply type byte wrong");
    rsp_group_a: assert property (d_take && didx == 8'h02 |-> d2h_data == 8'h02)
        else $error("reply group byte wrong");
    id_echo_a: assert property (d_take && didx == 8'h03 |-> d2h_data == hid)
        else $error("reply id differs from command");
    fix_len_a: assert property (d_take && didx == 8'h01 && (hid == 8'h0b || hid == 8'h0d)
        |-> d2h_data == 8'h02) else $error("fixed reply length wrong");
    arr_len_a: assert property (d_take && didx == 8'h06 |-> d2h_data == dlen - 8'h03)
        else $error("array length byte wrong");
    exec_start_a: assert property (h_last |=> !h2d_ready ##[1:3] d2h_valid)
        else $error("reply did not start in time");
    cover property (d_take && didx == 8'h03 && d2h_data == 8'h0a);
    cover property (d_take && didx == 8'h03 && d2h_data == 8'h0c);
    cover property (d_take && didx == 8'h03 && d2h_data == 8'h0d);
endmodule : sys_cmd_assertions

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    localparam logic [47:0] DIE = 48'h5a17_c3e9_0b42; // Arbitrary value
    logic clk_i = 1'b0, resetn_i = 1'b0, privacy_i = 1'b0;
    logic req_valid_i = 1'b0, pay_valid_i = 1'b0, rsp_ready_i = 1'b1;
    logic [7:0] req_id_i = 8'h00, req_len_i = 8'h00, req_cnt_i = 8'h00, pay_data_i = 8'h00;
    logic [15:0] req_off_i = 16'h0000;
    logic req_ready_o, req_err_o, pay_ready_o, rsp_valid_o, rsp_done_o, busy_o;
    logic [7:0] rsp_data_o, rsp_id_o;
    logic [15:0] rsp_result_o, text_len_o;
    logic [47:0] pub_addr_o, peer_addr_o;
    logic [7:0] pay [$], got [$], exp [$];
    int mem [256];
    int n_fail = 0, total_checks = 0, cyc = 0;
    cmd_link_if cmd_link_if_inst ();
    cmd_device #(.DIE_ID(DIE)) cmd_device_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .link(cmd_link_if_inst), .privacy_i(privacy_i), .pub_addr_o(pub_addr_o),
        .peer_addr_o(peer_addr_o), .text_len_o(text_len_o), .busy_o(busy_o));
    cmd_host cmd_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(cmd_link_if_inst),
        .req_valid_i(req_valid_i), .req_id_i(req_id_i), .req_len_i(req_len_i),
        .req_off_i(req_off_i), .req_cnt_i(req_cnt_i), .req_ready_o(req_ready_o),
        .req_err_o(req_err_o), .pay_valid_i(pay_valid_i), .pay_data_i(pay_data_i),
        .pay_ready_o(pay_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .rsp_ready_i(rsp_ready_i), .rsp_done_o(rsp_done_o), .rsp_result_o(rsp_result_o),
        .rsp_id_o(rsp_id_o));
    sys_cmd_assertions sys_cmd_assertions_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .h2d_valid(cmd_link_if_inst.h2d_valid), .h2d_data(cmd_link_if_inst.h2d_data),
        .h2d_ready(cmd_link_if_inst.h2d_ready), .d2h_valid(cmd_link_if_inst.d2h_valid),
        .d2h_data(cmd_link_if_inst.d2h_data), .d2h_ready(cmd_link_if_inst.d2h_ready));
    always #25 clk_i = ~clk_i;
    // Random stalls keep the reply buffer filling and draining
    always @(negedge clk_i) rsp_ready_i <= ($urandom % 4) != 0;
    always @(posedge clk_i) if (rsp_valid_o === 1'b1) got.push_back(rsp_data_o);
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [47:0] seen, input logic [47:0] want);
        total_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic run(input logic [7:0] id, input logic [15:0] off, input logic [7:0] cnt,
                       input logic err, input logic [15:0] res);
        got = {};
        req_id_i = id;
        req_len_i = 8'(pay.size());
        req_off_i = off;
        req_cnt_i = cnt;
        req_valid_i = 1'b1;
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        @(negedge clk_i);
        req_valid_i = 1'b0;
        chk(req_err_o, err);
        if (!err) begin
            // Valid stays up between bytes; the host drops ready after each take
            foreach (pay[i]) begin
                pay_data_i = pay[i];
                pay_valid_i = 1'b1;
                do @(posedge clk_i); while (pay_ready_o !== 1'b1);
                @(negedge clk_i);
            end
            pay_valid_i = 1'b0;
            chk(busy_o, 1'b1);
            do @(posedge clk_i); while (rsp_done_o !== 1'b1);
            @(negedge clk_i);
            chk(rsp_result_o, res);
            chk(rsp_id_o, id);
            chk(busy_o, 1'b0);
            chk(48'(got.size()), 48'(exp.size()));
            foreach (exp[i]) chk(got[i], exp[i]);
        end else begin
            @(negedge clk_i);
        end
        pay = {};
        exp = {};
    endtask : run
    task automatic wr(input int o, input int n);
        pay = {8'(o), 8'(o >> 8), 8'(n)};
        for (int k = 0; k < n; k++) begin
            mem[o + k] = $urandom % 256;
            pay.push_back(8'(mem[o + k]));
        end
        run(8'h0b, 16'(o), 8'(n), 1'b0, 16'h0000);
    endtask : wr
    task automatic rd(input int o, input int n);
        pay = {8'(o), 8'(o >> 8), 8'(n)};
        exp = {8'(n)};
        for (int k = 0; k < n; k++) exp.push_back(8'(mem[o + k]));
        run(8'h0c, 16'(o), 8'(n), 1'b0, 16'h0000);
        chk(text_len_o, 16'(13 + 2 * n));
    endtask : rd
    task automatic dec(input int m, input logic bad);
        logic [7:0] key [16], non [13];
        int p;
        foreach (key[i]) key[i] = $urandom % 256;
        foreach (non[i]) non[i] = $urandom % 256;
        pay = {bad ? 8'h00 : 8'(29 + m)};
        foreach (key[i]) pay.push_back(key[i]);
        foreach (non[i]) pay.push_back(non[i]);
        exp = {bad ? 8'h00 : 8'(m)};
        for (int i = 0; i < m; i++) begin
            p = $urandom % 256;
            if (!bad) exp.push_back(8'(p));
            pay.push_back(8'(p) ^ key[i % 16] ^ non[i % 13] ^ 8'(i));
        end
        run(8'h0a, 16'h0000, 8'h00, 1'b0, bad ? 16'h0102 : 16'h0000);
        if (!bad) chk(text_len_o, 16'(14 + 2 * m));
    endtask : dec
    task automatic adr(input logic [47:0] a, input logic [47:0] want);
        for (int k = 0; k < 6; k++) pay.push_back(a[8 * k +: 8]);
        run(8'h0d, 16'h0000, 8'h00, 1'b0, 16'h0000);
        chk(pub_addr_o, want);
        chk(peer_addr_o, want);
        privacy_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(peer_addr_o[47:46], 2'b11);
        privacy_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask : adr
    initial begin
        int n;
        logic [47:0] a;
        void'($urandom(32'hd379));
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        @(negedge clk_i);
        chk(pub_addr_o, DIE ^ {DIE[23:0], DIE[47:24]});
        wr(224, 32);
        rd(224, 32);
        wr(0, 1);
        rd(0, 1);
        repeat (4) begin
            n = 1 + $urandom % 32;
            wr($urandom % (257 - n), n);
            n = 1 + $urandom % 32;
            rd($urandom % (257 - n), n);
        end
        foreach (mem[i]) if (i < 8) wr(i * 32, 32);
        foreach (mem[i]) if (i < 8) rd(i * 32, 32);
        pay = {8'h00, 8'h00, 8'h00};
        run(8'h0c, 16'h00e1, 8'h20, 1'b1, 16'h0000);
        pay = {8'h00, 8'h00, 8'h00};
        run(8'h0b, 16'h0000, 8'h00, 1'b1, 16'h0000);
        pay = {8'h00};
        run(8'h0e, 16'h0000, 8'h00, 1'b1, 16'h0000);
        dec(1, 1'b0);
        dec(27, 1'b0);
        dec(1 + $urandom % 27, 1'b0);
        dec(5, 1'b1);
        a = {16'($urandom), $urandom};
        adr(a, a);
        adr(48'h0, DIE ^ {DIE[23:0], DIE[47:24]});
        final_report();
    end
endmodule : tb_top
